// ===== verilog/pwrseq_pkg.sv
// constants, types and register map of the power-up reset sequencer
`default_nettype none

package pwrseq_pkg;

  // timing
  localparam int CLK_PERIOD_NS  = 8;
  localparam int RC_TICK_NS     = 1000;
  localparam int RC_DIV         = RC_TICK_NS / CLK_PERIOD_NS;
  localparam int POWERUP_DELAY_TIMER_TIME_US   = 72000;
  localparam int POWERUP_DELAY_TIMER_TICKS     = (POWERUP_DELAY_TIMER_TIME_US * 1000) / RC_TICK_NS;
  localparam int POR_DELAY_NS   = 256;
  localparam int POR_DELAY_CYC  = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OST_CYCLES     = 1024;

  // configuration word
  localparam logic [13:0] CFG_SPACE_BASE = 14'h2000;
  localparam logic [13:0] CFG_SPACE_TOP  = 14'h3fff;
  localparam logic [13:0] CFG_WORD_ADDR  = 14'h2007;
  localparam logic [2:0]  CFG_WORD_IDX   = 3'(CFG_WORD_ADDR - CFG_SPACE_BASE);
  localparam logic [13:0] CFG_BLANK      = 14'h3fff;
  localparam int          CFG_POWERUP_DELAY_ENABLE_N_BIT  = 3;
  localparam int          CFG_WATCHDOG_ENABLE_CFG_BIT   = 2;

  typedef enum logic [1:0] {
    LOW_POWER_CRYSTAL_MODE  = 2'b00,
    STANDARD_CRYSTAL_MODE   = 2'b01,
    HIGH_SPEED_CRYSTAL_MODE = 2'b10,
    RC_OSC_MODE             = 2'b11
  } osc_mode_t;

  typedef struct packed {
    logic [1:0] cp_3;
    logic [1:0] cp_2;
    logic [1:0] cp_1;
    logic [1:0] unused;
    logic [1:0] code_protect_select;
    logic       powerup_delay_enable_n;
    logic       watchdog_enable_cfg;
    osc_mode_t  osc_mode_select;
  } cfg_word_t;

  // register byte offsets
  localparam logic [7:0] REG_PWR_CTRL_STAT = 8'h00;
  localparam logic [7:0] REG_IRQ_STATUS    = 8'h04;
  localparam logic [7:0] REG_IRQ_MASK      = 8'h08;
  localparam logic [7:0] REG_SEQ_STATUS    = 8'h0c;
  localparam logic [7:0] REG_CFG_SPACE     = 8'h40;
  localparam logic [7:0] REG_CFG_SPACE_END = 8'h5c;

  // fields and reset values
  localparam int         POWER_CONTROL_STATUS_POR_BIT     = 1;
  localparam logic [7:0] POWER_CONTROL_STATUS_RESET       = 8'h00;
  localparam int         IRQ_W            = 3;
  localparam int         IRQ_POR          = 0;
  localparam int         IRQ_STARTUP_DONE = 1;
  localparam int         IRQ_MASTER_CLEAR_PIN         = 2;
  localparam logic [2:0] IRQ_RESET        = 3'h0;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_PORD  = 3'b001,
    ST_POWERUP_DELAY_TIMER  = 3'b011,
    ST_OST   = 3'b010,
    ST_RUN   = 3'b110,
    ST_SLEEP = 3'b111
  } seq_state_t;

  typedef enum logic [2:0] {
    SEL_POWER_CONTROL_STATUS, SEL_IRQ_ST, SEL_IRQ_MASK, SEL_SEQ, SEL_SPACE, SEL_NONE
  } reg_sel_t;

endpackage

`default_nettype wire

// ===== verilog/cfg_space_mem.sv
// small memory for the first eight words of the test/configuration space
`default_nettype none

module cfg_space_mem (
  // clock
  input  wire logic        clk_i,
  // write port
  input  wire logic        wr_en_i,
  input  wire logic [2:0]  addr_i,
  input  wire logic [13:0] wr_data_i,
  // registered read port
  output logic      [13:0] rd_data_o
);

  logic [13:0] mem_q [8];

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_q[addr_i] <= mem_q[addr_i] & wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rd_data_o <= mem_q[addr_i];
  end

endmodule // cfg_space_mem

`default_nettype wire

// ===== verilog/pwrseq_top.sv
// power-on reset, power-up timer and oscillator settle sequencer with register slave
`default_nettype none

module pwrseq_top
  import pwrseq_pkg::*;
#(
  parameter int POWERUP_DELAY_TIMER_TICKS_P = POWERUP_DELAY_TIMER_TICKS
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // pins from outside the clock domain
  input  wire logic        supply_good_i,
  input  wire logic        master_clear_pin_n_i,
  input  wire logic        osc_input_pin_i,
  input  wire logic        prog_mode_i,
  // core side
  input  wire logic        sleep_req_i,
  input  wire logic        wake_i,
  output logic             core_rst_o,
  output logic             watchdog_enable_o,
  output logic [1:0]       osc_mode_o,
  output logic [1:0]       code_protect_o,
  output logic             irq_o,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o
);

  localparam int POWERUP_DELAY_TIMER_W = $clog2(POWERUP_DELAY_TIMER_TICKS_P + 1);
  localparam int RC_W   = $clog2(RC_DIV + 1);
  localparam int POR_W  = $clog2(POR_DELAY_CYC + 1);
  localparam int OST_W  = $clog2(OST_CYCLES + 1);

  function automatic reg_sel_t decode(input logic [7:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    if (a == REG_PWR_CTRL_STAT) begin
      s = SEL_POWER_CONTROL_STATUS;
    end else if (a == REG_IRQ_STATUS) begin
      s = SEL_IRQ_ST;
    end else if (a == REG_IRQ_MASK) begin
      s = SEL_IRQ_MASK;
    end else if (a == REG_SEQ_STATUS) begin
      s = SEL_SEQ;
    end else if (a >= REG_CFG_SPACE && a <= REG_CFG_SPACE_END && a[1:0] == 2'b00) begin
      s = SEL_SPACE;
    end
    return s;
  endfunction

  // pin synchronisers: only the second stage is read
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
    end else begin
      pin_s1_q <= {prog_mode_i, osc_input_pin_i, master_clear_pin_n_i, supply_good_i};
      pin_s2_q <= pin_s1_q;
    end
  end
  logic supply_s;
  logic master_clear_pin_n_s;
  logic osc_s;
  logic prog_s;
  assign supply_s = pin_s2_q[0];
  assign master_clear_pin_n_s = pin_s2_q[1];
  assign osc_s    = pin_s2_q[2];
  assign prog_s   = pin_s2_q[3];

  logic osc_prev_q;
  logic master_clear_pin_prev_q;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      osc_prev_q  <= 1'b0;
      master_clear_pin_prev_q <= 1'b0;
    end else begin
      osc_prev_q  <= osc_s;
      master_clear_pin_prev_q <= master_clear_pin_n_s;
    end
  end
  logic osc_rise;
  assign osc_rise = osc_s && !osc_prev_q;

  // configuration shadow: writes only take bits from one to zero; sys_rst_i reloads the blank word
  cfg_word_t cfg_q;
  logic      is_xtal;
  assign is_xtal = (cfg_q.osc_mode_select != RC_OSC_MODE);

  // bus slave handshake
  logic     pend_q;
  logic     wait_q;
  logic     commit_wr;
  reg_sel_t sel;
  assign sel       = decode(avs_address_i);
  assign commit_wr = !wait_q && avs_write_i;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_q <= 1'b0;
      wait_q <= 1'b1;
    end else begin
      pend_q <= (avs_read_i || avs_write_i) && wait_q && !pend_q;
      wait_q <= !(pend_q && wait_q);
    end
  end
  assign avs_waitrequest_o = wait_q;

  logic space_wr;
  assign space_wr = commit_wr && sel == SEL_SPACE && prog_s;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_q <= CFG_BLANK;
    end else if (space_wr && avs_address_i[4:2] == CFG_WORD_IDX) begin
      cfg_q <= cfg_q & avs_writedata_i[13:0];
    end
  end

  logic [13:0] mem_rdata;
  cfg_space_mem u_mem (
    .clk_i     (clk_i),
    .wr_en_i   (space_wr),
    .addr_i    (avs_address_i[4:2]),
    .wr_data_i (avs_writedata_i[13:0]),
    .rd_data_o (mem_rdata)
  );

  // sequencer
  seq_state_t          state_q;
  seq_state_t          state_d;
  logic [POR_W-1:0]    por_cnt_q;
  logic [RC_W-1:0]     rc_div_q;
  logic                rc_tick;
  logic [POWERUP_DELAY_TIMER_W-1:0]   powerup_delay_timer_cnt_q;
  logic [OST_W-1:0]    ost_cnt_q;
  logic                por_done;
  logic                powerup_delay_timer_done;
  logic                ost_done;

  assign rc_tick   = (rc_div_q == RC_W'(RC_DIV - 1));
  assign por_done  = (por_cnt_q == POR_W'(POR_DELAY_CYC - 1));
  assign powerup_delay_timer_done = rc_tick && (powerup_delay_timer_cnt_q == POWERUP_DELAY_TIMER_W'(POWERUP_DELAY_TIMER_TICKS_P - 1));
  assign ost_done  = osc_rise && (ost_cnt_q == OST_W'(OST_CYCLES - 1));

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF:   if (supply_s) state_d = ST_PORD;
      ST_PORD: begin
        if (por_done) begin
          if (!cfg_q.powerup_delay_enable_n) begin
            state_d = ST_POWERUP_DELAY_TIMER;
          end else if (is_xtal) begin
            state_d = ST_OST;
          end else begin
            state_d = ST_RUN;
          end
        end
      end
      ST_POWERUP_DELAY_TIMER:  if (powerup_delay_timer_done) state_d = is_xtal ? ST_OST : ST_RUN;
      ST_OST:   if (ost_done) state_d = ST_RUN;
      ST_RUN:   if (sleep_req_i) state_d = ST_SLEEP;
      ST_SLEEP: if (wake_i) state_d = is_xtal ? ST_OST : ST_RUN;
      default:  state_d = ST_OFF;
    endcase
    if (!supply_s) begin
      state_d = ST_OFF;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // stands in for the dedicated rc oscillator: free running, independent of the main osc
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rc_div_q <= '0;
    end else if (rc_tick) begin
      rc_div_q <= '0;
    end else begin
      rc_div_q <= rc_div_q + RC_W'(1);
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      por_cnt_q <= '0;
    end else if (state_q != ST_PORD) begin
      por_cnt_q <= '0;
    end else if (!por_done) begin
      por_cnt_q <= por_cnt_q + POR_W'(1);
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      powerup_delay_timer_cnt_q <= '0;
    end else if (state_q != ST_POWERUP_DELAY_TIMER) begin
      powerup_delay_timer_cnt_q <= '0;
    end else if (rc_tick) begin
      powerup_delay_timer_cnt_q <= powerup_delay_timer_cnt_q + POWERUP_DELAY_TIMER_W'(1);
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ost_cnt_q <= '0;
    end else if (state_q != ST_OST) begin
      ost_cnt_q <= '0;
    end else if (osc_rise) begin
      ost_cnt_q <= ost_cnt_q + OST_W'(1);
    end
  end

  // core reset ignores master clear until the delays end, so release is immediate after
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      core_rst_o <= 1'b1;
    end else begin
      core_rst_o <= !(state_q == ST_RUN || state_q == ST_SLEEP) || !master_clear_pin_n_s;
    end
  end

  // config-driven outputs; the watchdog has no software off switch
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      watchdog_enable_o <= CFG_BLANK[CFG_WATCHDOG_ENABLE_CFG_BIT];
      osc_mode_o        <= CFG_BLANK[1:0];
      code_protect_o    <= CFG_BLANK[5:4];
    end else begin
      watchdog_enable_o <= cfg_q.watchdog_enable_cfg;
      osc_mode_o        <= cfg_q.osc_mode_select;
      code_protect_o    <= cfg_q.code_protect_select;
    end
  end

  // power status: the power-on clear beats a software set in the same cycle
  logic por_evt;
  assign por_evt = (state_q == ST_OFF) && (state_d == ST_PORD);
  logic por_flag_q;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      por_flag_q <= POWER_CONTROL_STATUS_RESET[POWER_CONTROL_STATUS_POR_BIT];
    end else if (por_evt) begin
      por_flag_q <= 1'b0;
    end else if (commit_wr && sel == SEL_POWER_CONTROL_STATUS) begin
      por_flag_q <= avs_writedata_i[POWER_CONTROL_STATUS_POR_BIT];
    end
  end

  // interrupts: sticky, write one to clear, a new event wins over the clear
  logic [IRQ_W-1:0] irq_st_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] irq_clr;
  always_comb begin
    irq_evt                   = '0;
    irq_evt[IRQ_POR]          = por_evt;
    irq_evt[IRQ_STARTUP_DONE] = (state_d == ST_RUN) && (state_q inside {ST_PORD, ST_POWERUP_DELAY_TIMER, ST_OST});
    irq_evt[IRQ_MASTER_CLEAR_PIN]         = master_clear_pin_prev_q && !master_clear_pin_n_s;
    irq_clr = (commit_wr && sel == SEL_IRQ_ST) ? avs_writedata_i[IRQ_W-1:0] : '0;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_st_q   <= IRQ_RESET;
      irq_mask_q <= IRQ_RESET;
      irq_o      <= 1'b0;
    end else begin
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_evt;
      if (commit_wr && sel == SEL_IRQ_MASK) begin
        irq_mask_q <= avs_writedata_i[IRQ_W-1:0];
      end
      irq_o <= |(((irq_st_q & ~irq_clr) | irq_evt) & irq_mask_q);
    end
  end

  // read data; config space reads zero outside programming mode
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      avs_readdata_o <= 32'h0;
    end else if (pend_q && wait_q) begin
      avs_readdata_o <= 32'h0;
      case (sel)
        SEL_POWER_CONTROL_STATUS:     avs_readdata_o[POWER_CONTROL_STATUS_POR_BIT] <= por_flag_q;
        SEL_IRQ_ST:   avs_readdata_o[IRQ_W-1:0] <= irq_st_q;
        SEL_IRQ_MASK: avs_readdata_o[IRQ_W-1:0] <= irq_mask_q;
        SEL_SEQ:      avs_readdata_o[5:0] <= {prog_s, master_clear_pin_n_s, core_rst_o, state_q};
        SEL_SPACE: begin
          if (prog_s) begin
            avs_readdata_o[13:0] <= (avs_address_i[4:2] == CFG_WORD_IDX) ? cfg_q : mem_rdata;
          end
        end
        default:      avs_readdata_o <= 32'h0;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_powerup_delay_timer_enable: assert property ($rose(state_q == ST_POWERUP_DELAY_TIMER) |-> !cfg_q.powerup_delay_enable_n)
    else $error("power-up timer started while disabled");
  a_powerup_delay_timer_length: assert property (state_q == ST_POWERUP_DELAY_TIMER && !powerup_delay_timer_done && supply_s |=> state_q == ST_POWERUP_DELAY_TIMER)
    else $error("power-up timer left early");
  a_core_held: assert property (state_q inside {ST_OFF, ST_PORD, ST_POWERUP_DELAY_TIMER, ST_OST} |=> core_rst_o)
    else $error("core released during start-up");
  a_settle_count: assert property (state_q == ST_OST && ost_done && supply_s |=> state_q == ST_RUN ##1 !core_rst_o || !$past(master_clear_pin_n_s))
    else $error("settle count end did not release core");
  a_settle_mode: assert property ($rose(state_q == ST_OST) |-> is_xtal && $past(state_q) inside {ST_PORD, ST_POWERUP_DELAY_TIMER, ST_SLEEP})
    else $error("settle count in wrong mode or order");
  a_rc_nodelay: assert property (state_q == ST_PORD && por_done && supply_s && !is_xtal && cfg_q.powerup_delay_enable_n |=> state_q == ST_RUN)
    else $error("rc mode with timer off still delayed");
  a_master_clear_pin_release: assert property (state_q == ST_RUN && $rose(master_clear_pin_n_s) |=> !core_rst_o)
    else $error("master clear release not immediate");
  a_por_flag: assert property (por_evt |=> !por_flag_q)
    else $error("power-on status not cleared");
  a_cfg_locked: assert property (commit_wr && !prog_s |=> $stable(cfg_q))
    else $error("config changed outside programming mode");
  a_wdt_follow: assert property (##1 watchdog_enable_o == $past(cfg_q.watchdog_enable_cfg))
    else $error("watchdog enable does not follow config");

endmodule // pwrseq_top

`default_nettype wire

// ===== verification/pwr_partner.sv
// model of the supply monitor, master clear pin and crystal on the sequencer's far side
`default_nettype none

module pwr_partner (
  // clock
  input  wire logic clk_i,
  // commands from the bench
  input  wire logic supply_on_i,
  input  wire logic master_clear_pin_hold_i,
  input  wire logic osc_run_i,
  // pins toward the sequencer
  output logic      supply_good_o,
  output logic      master_clear_pin_n_o,
  output logic      osc_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] div_q;

  assign supply_good_o        = supply_on_i;
  // pin tied high through a resistor unless held low by the outside party
  assign master_clear_pin_n_o = !master_clear_pin_hold_i;

  // crystal at clk/8; a stopped crystal simply freezes, so no edges reach the counter
  initial div_q = 2'h0;
  initial osc_pin_o = 1'b0;
  always @(posedge clk_i) begin
    if (osc_run_i) begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) osc_pin_o <= !osc_pin_o;
    end
  end
endmodule  // pwr_partner

`default_nettype wire

// ===== verification/tb_pwrseq_top.sv
// self-checking bench for the power-up reset sequencer
`default_nettype none

module tb_pwrseq_top
  import pwrseq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PT   = 20;
  localparam int PCYC = PT * RC_DIV;

  logic        clk_i, sys_rst_i, prog_mode_i, sleep_req_i, wake_i;
  logic        supply_on, master_clear_pin_hold, osc_run;
  logic        supply_good, master_clear_pin_n, osc_pin;
  logic        core_rst, wdt_en, irq;
  logic [1:0]  osc_mode, cp;
  logic [7:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rd;
  int          err_count, checks, cyc;

  pwr_partner pwr_partner_i (.clk_i(clk_i), .supply_on_i(supply_on), .master_clear_pin_hold_i(master_clear_pin_hold),
    .osc_run_i(osc_run), .supply_good_o(supply_good), .master_clear_pin_n_o(master_clear_pin_n),
    .osc_pin_o(osc_pin));

  pwrseq_top #(.POWERUP_DELAY_TIMER_TICKS_P(PT)) pwrseq_top_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .supply_good_i(supply_good), .master_clear_pin_n_i(master_clear_pin_n), .osc_input_pin_i(osc_pin),
    .prog_mode_i(prog_mode_i), .sleep_req_i(sleep_req_i), .wake_i(wake_i),
    .core_rst_o(core_rst), .watchdog_enable_o(wdt_en), .osc_mode_o(osc_mode),
    .code_protect_o(cp), .irq_o(irq), .avs_address_i(avs_address), .avs_read_i(avs_read),
    .avs_write_i(avs_write), .avs_writedata_i(avs_writedata), .avs_readdata_o(avs_readdata),
    .avs_waitrequest_o(avs_waitrequest));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = !clk_i;
  end

  task automatic complete_run;
    if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // the run should finish near 28k cycles; this only cuts a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // one avalon transfer; request held until waitrequest is seen low at an edge
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= we;
    avs_read      <= !we;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) chk(32'h0, 32'hdead);
  endtask

  task automatic wait_state(input seq_state_t s, input int tries);
    int n;
    n = 0;
    do begin
      bus(1'b0, REG_SEQ_STATUS, 32'h0);
      n++;
    end while (rd[2:0] !== s && n < tries);
    chk(32'(rd[2:0]), 32'(s));
  endtask

  task automatic pulse_sleep(input logic wake);
    @(posedge clk_i);
    if (wake) wake_i <= 1'b1;
    else sleep_req_i <= 1'b1;
    @(posedge clk_i);
    wake_i      <= 1'b0;
    sleep_req_i <= 1'b0;
  endtask

  task automatic do_reset;
    sys_rst_i <= 1'b1;
    ticks(6);
    sys_rst_i <= 1'b0;
    ticks(1);
  endtask

  task automatic s_reset_values;
    chk(32'(core_rst), 32'h1);
    chk(32'(osc_mode), 32'h3);
    chk(32'(wdt_en), 32'h1);
    bus(1'b0, REG_PWR_CTRL_STAT, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 8'h80, 32'h0);
    chk(rd, 32'h0);
  endtask

  task automatic s_config;
    prog_mode_i <= 1'b1;
    ticks(4);
    bus(1'b0, REG_CFG_SPACE_END, 32'h0);
    chk(rd, 32'h3fff);
    bus(1'b1, REG_CFG_SPACE_END, 32'h3ff1);
    bus(1'b1, REG_CFG_SPACE_END, 32'h3fff);
    bus(1'b0, REG_CFG_SPACE_END, 32'h0);
    chk(rd, 32'h3ff1);
    prog_mode_i <= 1'b0;
    ticks(4);
    bus(1'b0, REG_CFG_SPACE_END, 32'h0);
    chk(rd, 32'h0);
    // a write outside programming mode must leave the word as it was
    bus(1'b1, REG_CFG_SPACE_END, 32'h0);
    ticks(2);
    chk(32'(osc_mode), 32'(STANDARD_CRYSTAL_MODE));
    chk(32'(wdt_en), 32'h0);
    chk(32'(cp), 32'h3);
  endtask

  task automatic s_powerup_crystal;
    int n;
    supply_on <= 1'b1;
    ticks(POR_DELAY_CYC + PCYC - RC_DIV - 20);
    bus(1'b0, REG_SEQ_STATUS, 32'h0);
    chk(32'(rd[2:0]), 32'(ST_POWERUP_DELAY_TIMER));
    chk(32'(core_rst), 32'h1);
    ticks(2 * RC_DIV + 20);
    bus(1'b0, REG_SEQ_STATUS, 32'h0);
    chk(32'(rd[2:0]), 32'(ST_OST));
    chk(32'(core_rst), 32'h1);
    osc_run <= 1'b1;
    n = 0;
    while (core_rst !== 1'b0 && n < 12000) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(n > 8 * (OST_CYCLES - 4)), 32'h1);
    chk(32'(core_rst), 32'h0);
    bus(1'b0, REG_IRQ_STATUS, 32'h0);
    chk(rd, 32'h3);
    bus(1'b0, REG_PWR_CTRL_STAT, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, REG_PWR_CTRL_STAT, 32'h2);
    bus(1'b0, REG_PWR_CTRL_STAT, 32'h0);
    chk(rd, 32'h2);
  endtask

  task automatic s_sleep_wake;
    osc_run <= 1'b0;
    pulse_sleep(1'b0);
    wait_state(ST_SLEEP, 3);
    pulse_sleep(1'b1);
    bus(1'b0, REG_SEQ_STATUS, 32'h0);
    chk(32'(rd[2:0]), 32'(ST_OST));
    osc_run <= 1'b1;
    wait_state(ST_RUN, 3500);
  endtask

  task automatic s_irq_master_clear_pin;
    bus(1'b1, REG_IRQ_STATUS, 32'h7);
    bus(1'b1, REG_IRQ_MASK, 32'h4);
    chk(32'(irq), 32'h0);
    master_clear_pin_hold <= 1'b1;
    ticks(8);
    chk(32'(irq), 32'h1);
    chk(32'(core_rst), 32'h1);
    master_clear_pin_hold <= 1'b0;
    ticks(8);
    chk(32'(core_rst), 32'h0);
    bus(1'b0, REG_PWR_CTRL_STAT, 32'h0);
    chk(rd, 32'h2);
    bus(1'b1, REG_IRQ_STATUS, 32'h4);
    ticks(2);
    chk(32'(irq), 32'h0);
    bus(1'b1, REG_IRQ_MASK, 32'h0);
    master_clear_pin_hold <= 1'b1;
    ticks(8);
    master_clear_pin_hold <= 1'b0;
    chk(32'(irq), 32'h0);
    bus(1'b0, REG_IRQ_STATUS, 32'h0);
    chk(rd, 32'h4);
  endtask

  // blank config: rc mode with the timer off, master clear held past the sequence
  task automatic s_rc_no_delay;
    // a supply bounce is a power-on: the flag set by software must clear
    supply_on <= 1'b0;
    ticks(4);
    supply_on <= 1'b1;
    ticks(6);
    bus(1'b0, REG_PWR_CTRL_STAT, 32'h0);
    chk(rd, 32'h0);
    supply_on <= 1'b0;
    master_clear_pin_hold <= 1'b1;
    osc_run   <= 1'b0;
    do_reset();
    supply_on <= 1'b1;
    wait_state(ST_RUN, 20);
    chk(32'(core_rst), 32'h1);
    master_clear_pin_hold <= 1'b0;
    ticks(5);
    chk(32'(core_rst), 32'h0);
  endtask

  // high-speed then low-power crystal with the timer disabled: settle count only
  task automatic s_xtal_no_timer;
    prog_mode_i <= 1'b1;
    ticks(4);
    bus(1'b1, REG_CFG_SPACE_END, 32'h3ffe);
    ticks(2);
    chk(32'(osc_mode), 32'(HIGH_SPEED_CRYSTAL_MODE));
    bus(1'b1, REG_CFG_SPACE_END, 32'h3ffc);
    prog_mode_i <= 1'b0;
    ticks(2);
    chk(32'(osc_mode), 32'(LOW_POWER_CRYSTAL_MODE));
    supply_on <= 1'b0;
    osc_run   <= 1'b0;
    ticks(4);
    supply_on <= 1'b1;
    wait_state(ST_OST, 20);
    chk(32'(core_rst), 32'h1);
    osc_run <= 1'b1;
    wait_state(ST_RUN, 3500);
    chk(32'(core_rst), 32'h0);
  endtask

  initial begin
    sys_rst_i     = 1'b1;
    prog_mode_i   = 1'b0;
    sleep_req_i   = 1'b0;
    wake_i        = 1'b0;
    supply_on     = 1'b0;
    master_clear_pin_hold     = 1'b0;
    osc_run       = 1'b0;
    avs_address   = 8'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    err_count     = 0;
    checks        = 0;
    cyc           = 0;
    do_reset();
    s_reset_values();
    s_config();
    s_powerup_crystal();
    s_sleep_wake();
    s_irq_master_clear_pin();
    s_rc_no_delay();
    s_xtal_no_timer();
    complete_run();
  end
endmodule  // tb_pwrseq_top

`default_nettype wire
